// ---- logic/l2_arb_pkg.sv ----
// Shared constants for the L2 bandwidth arbiter and its requester end.
// Assumes a 25-bit byte address space and 32-bit register words.
package l2_arb_pkg;
  localparam int          ADDR_W         = 25;
  localparam int          PRI_W          = 3;
  localparam int          CNT_W          = 6;
  localparam int          MID_W          = 4;
  // Register byte addresses
  localparam logic [24:0] INTERNAL_DMA_CH1_COUNT_OFS  = 25'h1820110;
  localparam logic [24:0] MASTER_PRIORITY_0_OFS = 25'h1c4003c;
  localparam logic [24:0] MASTER_PRIORITY_1_OFS = 25'h1c40040;
  localparam logic [24:0] CORE_ARB_CTRL_OFS   = 25'h1820200;
  localparam logic [24:0] ARB_STATUS_OFS      = 25'h1820204;
  // Field positions
  localparam int          CORE_PRI_POS   = 0;
  localparam int          LIMIT_POS      = 16;
  localparam int          INTERNAL_DMA_PRIORITY_FIELD_POS   = 29;
  localparam int          MST_FIELD_W    = 4;
  // Reset values
  localparam logic [2:0]  CORE_PRI_RST   = 3'h1;
  localparam logic [5:0]  LIMIT_RST      = 6'h10;
  localparam logic [2:0]  DMA_PRI_RST    = 3'h2;
  localparam logic [31:0] MST_PRI_RST    = 32'h22222222;
  // Effective slave port priority once its commands are all issued
  localparam logic [2:0]  LOWERED_PRI    = 3'h7;
  localparam logic [5:0]  CNT_MAX        = 6'h3f;
endpackage

// ---- logic/l2_arb_if.sv ----
// Link between the L2 arbiter and the requester end.
// Assumes both ends share clk and the synchronous reset.
`timescale 1ns/1ns
interface l2_arb_if;
  logic        core_req;
  logic        internal_dma_req;
  logic        slave_dma_port_req;
  logic        slave_dma_port_done;
  logic [3:0]  slave_dma_port_mid;
  logic        core_gnt;
  logic        internal_dma_gnt;
  logic        slave_dma_port_gnt;
  logic [24:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;

  modport device (
    input  core_req, internal_dma_req, slave_dma_port_req, slave_dma_port_done, slave_dma_port_mid,
    input  reg_addr, reg_wdata, reg_wr, reg_rd,
    output core_gnt, internal_dma_gnt, slave_dma_port_gnt, reg_rdata
  );
  modport requester (
    output core_req, internal_dma_req, slave_dma_port_req, slave_dma_port_done, slave_dma_port_mid,
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    input  core_gnt, internal_dma_gnt, slave_dma_port_gnt, reg_rdata
  );
endinterface // l2_arb_if

// ---- logic/l2_bandwidth_arbiter.sv ----
// L2 RAM bandwidth arbiter: core, internal DMA and slave DMA port.
// Assumes requests are levels held until granted, all on clk.
`timescale 1ns/1ns
module l2_bandwidth_arbiter (
  input  wire logic clk,
  input  wire logic rst_n,
  l2_arb_if.device  bus,
  output logic [2:0] slave_dma_port_eff_pri,
  output logic       core_favoured
);
  // Configuration registers
  logic [2:0]  core_pri_r,  core_pri_nxt;
  logic [5:0]  limit_r,     limit_nxt;
  logic [31:0] internal_dma_cnt_r,  internal_dma_cnt_nxt;
  logic [31:0] mst0_r,      mst0_nxt;
  logic [31:0] mst1_r,      mst1_nxt;
  logic [31:0] rdata_r,     rdata_nxt;
  // Arbitration state
  logic [5:0]  cnt_r [2],   cnt_nxt [2];
  logic        rr_r,        rr_nxt;
  logic [2:0]  gnt;
  logic [2:0]  pri [3];
  logic [2:0]  req;
  logic [2:0]  slave_dma_port_pri;
  logic [31:0] mst_sel;
  logic [2:0]  dma_win;

  // Register writes and registered read data
  always_comb begin
    core_pri_nxt = core_pri_r;
    limit_nxt    = limit_r;
    internal_dma_cnt_nxt = internal_dma_cnt_r;
    mst0_nxt     = mst0_r;
    mst1_nxt     = mst1_r;
    rdata_nxt    = 32'h00000000;
    if (bus.reg_wr) begin
      unique case (bus.reg_addr)
        l2_arb_pkg::CORE_ARB_CTRL_OFS: begin
          core_pri_nxt = bus.reg_wdata[l2_arb_pkg::CORE_PRI_POS +: 3];
          limit_nxt    = bus.reg_wdata[l2_arb_pkg::LIMIT_POS +: 6];
        end
        l2_arb_pkg::INTERNAL_DMA_CH1_COUNT_OFS:    internal_dma_cnt_nxt = bus.reg_wdata;
        l2_arb_pkg::MASTER_PRIORITY_0_OFS: mst0_nxt = bus.reg_wdata;
        l2_arb_pkg::MASTER_PRIORITY_1_OFS: mst1_nxt = bus.reg_wdata;
        default: ;
      endcase
    end
    if (bus.reg_rd) begin
      unique case (bus.reg_addr)
        l2_arb_pkg::CORE_ARB_CTRL_OFS:
          rdata_nxt = {10'h000, limit_r, 13'h0000, core_pri_r};
        l2_arb_pkg::INTERNAL_DMA_CH1_COUNT_OFS:    rdata_nxt = internal_dma_cnt_r;
        l2_arb_pkg::MASTER_PRIORITY_0_OFS: rdata_nxt = mst0_r;
        l2_arb_pkg::MASTER_PRIORITY_1_OFS: rdata_nxt = mst1_r;
        l2_arb_pkg::ARB_STATUS_OFS:
          rdata_nxt = {11'h000, slave_dma_port_eff_pri, cnt_r[1], 2'h0,
                       cnt_r[0], 1'b0, gnt};
        default:                           rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_pri_r <= l2_arb_pkg::CORE_PRI_RST;
      limit_r    <= l2_arb_pkg::LIMIT_RST;
      internal_dma_cnt_r <= {l2_arb_pkg::DMA_PRI_RST, 29'h00000000};
      mst0_r     <= l2_arb_pkg::MST_PRI_RST;
      mst1_r     <= l2_arb_pkg::MST_PRI_RST;
      rdata_r    <= 32'h00000000;
    end else begin
      core_pri_r <= core_pri_nxt;
      limit_r    <= limit_nxt;
      internal_dma_cnt_r <= internal_dma_cnt_nxt;
      mst0_r     <= mst0_nxt;
      mst1_r     <= mst1_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign bus.reg_rdata = rdata_r;

  // Slave port priority from the originating master's field
  always_comb begin
    mst_sel  = bus.slave_dma_port_mid[3] ? mst1_r : mst0_r;
    slave_dma_port_pri = mst_sel[{bus.slave_dma_port_mid[2:0], 2'b00} +: 3];
    slave_dma_port_eff_pri = bus.slave_dma_port_done ? l2_arb_pkg::LOWERED_PRI
                                 : slave_dma_port_pri;
  end

  // Requester table: index 0 core, 1 internal DMA, 2 slave port
  always_comb begin
    req    = {bus.slave_dma_port_req, bus.internal_dma_req, bus.core_req};
    pri[0] = core_pri_r;
    pri[1] = internal_dma_cnt_r[l2_arb_pkg::INTERNAL_DMA_PRIORITY_FIELD_POS +: 3];
    pri[2] = slave_dma_port_eff_pri;
  end

  // Pick the stronger DMA requester, equal levels alternate
  always_comb begin
    dma_win = 3'h0;
    if (req[1] && req[2]) begin
      if (pri[1] < pri[2])
        dma_win = 3'h2;
      else if (pri[2] < pri[1])
        dma_win = 3'h4;
      else
        dma_win = rr_r ? 3'h4 : 3'h2;
    end else if (req[1]) begin
      dma_win = 3'h2;
    end else if (req[2]) begin
      dma_win = 3'h4;
    end
  end

  // Grant decision
  always_comb begin
    logic starve1;
    logic starve2;
    starve1 = 1'b0;
    starve2 = 1'b0;
    gnt     = 3'h0;
    core_favoured = 1'b0;
    starve1 = req[1] && limit_r != 6'h00 && cnt_r[0] >= limit_r;
    starve2 = req[2] && limit_r != 6'h00 && cnt_r[1] >= limit_r;
    if (starve1 && !(rr_r && starve2))
      gnt = 3'h2;
    else if (starve2)
      gnt = 3'h4;
    else if (req[0]) begin
      gnt = 3'h1;
      // Inversion: core still wins at lower or equal level
      core_favoured = dma_win != 3'h0 &&
        ((dma_win[1] && pri[0] >= pri[1]) ||
         (dma_win[2] && pri[0] >= pri[2]));
    end else
      gnt = dma_win;
  end

  assign bus.core_gnt = gnt[0];
  assign bus.internal_dma_gnt = gnt[1];
  assign bus.slave_dma_port_gnt = gnt[2];

  // Contention counters and tie toggle
  always_comb begin
    logic blocked;
    blocked = 1'b0;
    rr_nxt  = rr_r;
    if ((gnt[1] || gnt[2]) && req[1] && req[2])
      rr_nxt = gnt[1];
    for (int i = 0; i < 2; i++) begin
      blocked = 1'b0;
      for (int j = 0; j < 3; j++)
        if (gnt[j] && pri[j] < pri[i + 1])
          blocked = 1'b1;
      if (gnt[i + 1] || !req[i + 1])
        cnt_nxt[i] = 6'h00;
      else if (blocked && cnt_r[i] != l2_arb_pkg::CNT_MAX)
        cnt_nxt[i] = cnt_r[i] + 6'h01;
      else
        cnt_nxt[i] = cnt_r[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r[0] <= 6'h00;
      cnt_r[1] <= 6'h00;
      rr_r     <= 1'b0;
    end else begin
      cnt_r[0] <= cnt_nxt[0];
      cnt_r[1] <= cnt_nxt[1];
      rr_r     <= rr_nxt;
    end
  end
endmodule // l2_bandwidth_arbiter

// ---- logic/l2_requester_end.sv ----
// Requester end: holds core and DMA requests, forwards register access.
// Assumes the arbiter answers reads one cycle after the read strobe.
`timescale 1ns/1ns
module l2_requester_end (
  input  wire logic        clk,
  input  wire logic        rst_n,
  l2_arb_if.requester      bus,
  input  wire logic        core_req_in,
  input  wire logic        internal_dma_req_in,
  input  wire logic        slave_dma_port_req_in,
  input  wire logic        slave_dma_port_done_in,
  input  wire logic [3:0]  slave_dma_port_mid_in,
  input  wire logic [24:0] sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [31:0]      sw_rdata,
  output logic [2:0]       gnt_out,
  output logic             cfg_illegal
);
  logic [2:0]  pend_r,   pend_nxt;
  logic [2:0]  core_r,   core_nxt;
  logic [2:0]  internal_dma_r,   internal_dma_nxt;
  logic [31:0] mst0_r,   mst0_nxt;
  logic [31:0] mst1_r,   mst1_nxt;
  logic [2:0]  slave_dma_port_pri;
  logic [31:0] mst_sel;

  // Pending requests held until granted
  always_comb begin
    gnt_out  = {bus.slave_dma_port_gnt, bus.internal_dma_gnt, bus.core_gnt};
    pend_nxt = (pend_r | {slave_dma_port_req_in, internal_dma_req_in, core_req_in})
               & ~gnt_out;
  end

  // Shadow the priority settings that software writes
  always_comb begin
    core_nxt = core_r;
    internal_dma_nxt = internal_dma_r;
    mst0_nxt = mst0_r;
    mst1_nxt = mst1_r;
    if (sw_wr) begin
      unique case (sw_addr)
        l2_arb_pkg::CORE_ARB_CTRL_OFS:
          core_nxt = sw_wdata[l2_arb_pkg::CORE_PRI_POS +: 3];
        l2_arb_pkg::INTERNAL_DMA_CH1_COUNT_OFS:
          internal_dma_nxt = sw_wdata[l2_arb_pkg::INTERNAL_DMA_PRIORITY_FIELD_POS +: 3];
        l2_arb_pkg::MASTER_PRIORITY_0_OFS: mst0_nxt = sw_wdata;
        l2_arb_pkg::MASTER_PRIORITY_1_OFS: mst1_nxt = sw_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_r <= 3'h0;
      core_r <= l2_arb_pkg::CORE_PRI_RST;
      internal_dma_r <= l2_arb_pkg::DMA_PRI_RST;
      mst0_r <= l2_arb_pkg::MST_PRI_RST;
      mst1_r <= l2_arb_pkg::MST_PRI_RST;
    end else begin
      pend_r <= pend_nxt;
      core_r <= core_nxt;
      internal_dma_r <= internal_dma_nxt;
      mst0_r <= mst0_nxt;
      mst1_r <= mst1_nxt;
    end
  end

  // Flag core priority 0 or 7, or a DMA priority value at or above the core's
  always_comb begin
    mst_sel     = slave_dma_port_mid_in[3] ? mst1_r : mst0_r;
    slave_dma_port_pri    = mst_sel[{slave_dma_port_mid_in[2:0], 2'b00} +: 3];
    cfg_illegal = core_r == 3'h0 || core_r == l2_arb_pkg::LOWERED_PRI ||
                  internal_dma_r >= core_r || slave_dma_port_pri >= core_r;
  end

  // Drive the link
  assign bus.core_req  = pend_r[0];
  assign bus.internal_dma_req  = pend_r[1];
  assign bus.slave_dma_port_req  = pend_r[2];
  assign bus.slave_dma_port_done = slave_dma_port_done_in;
  assign bus.slave_dma_port_mid  = slave_dma_port_mid_in;
  assign bus.reg_addr  = sw_addr;
  assign bus.reg_wdata = sw_wdata;
  assign bus.reg_wr    = sw_wr;
  assign bus.reg_rd    = sw_rd;
  assign sw_rdata      = bus.reg_rdata;
endmodule // l2_requester_end

// ---- tb/l2_bandwidth_arbiter_chk.sv ----
// Timing checks on the link between arbiter and requester end.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module l2_bandwidth_arbiter_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        core_req,
  input wire logic        internal_dma_req,
  input wire logic        slave_dma_port_req,
  input wire logic        slave_dma_port_done,
  input wire logic [3:0]  slave_dma_port_mid,
  input wire logic        core_gnt,
  input wire logic        internal_dma_gnt,
  input wire logic        slave_dma_port_gnt,
  input wire logic [24:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Write then read back of one register
  sequence s_ctrl_wr_rd;
    reg_wr && reg_addr == l2_arb_pkg::CORE_ARB_CTRL_OFS ##1
    reg_rd && reg_addr == l2_arb_pkg::CORE_ARB_CTRL_OFS;
  endsequence
  sequence s_mst_wr_rd;
    reg_wr && reg_addr == l2_arb_pkg::MASTER_PRIORITY_0_OFS ##1
    reg_rd && reg_addr == l2_arb_pkg::MASTER_PRIORITY_0_OFS;
  endsequence
  // Grant rules
  a_grant_one_hot: assert property (
    $onehot0({slave_dma_port_gnt, internal_dma_gnt, core_gnt})) else $error("two grants");
  a_grant_has_req: assert property (
    ({slave_dma_port_gnt, internal_dma_gnt, core_gnt} & ~{slave_dma_port_req, internal_dma_req, core_req})
    == 3'h0) else $error("grant without request");
  a_work_kept: assert property (
    (core_req || internal_dma_req || slave_dma_port_req) |-> (core_gnt || internal_dma_gnt || slave_dma_port_gnt))
    else $error("pending request but no grant");
  a_core_alone: assert property (
    core_req && !internal_dma_req && !slave_dma_port_req |-> core_gnt)
    else $error("lone core request not granted");
  a_pend_clears: assert property (
    1'b1 |=> ({slave_dma_port_req, internal_dma_req, core_req}
    & $past({slave_dma_port_gnt, internal_dma_gnt, core_gnt})) == 3'h0)
    else $error("request still pending after grant");
  // Register port rules
  a_read_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0) else $error("read data without read");
  a_ctrl_readback: assert property (
    s_ctrl_wr_rd |=> reg_rdata[21:0] == {$past(reg_wdata[21:16], 2), 13'h0,
    $past(reg_wdata[2:0], 2)}) else $error("control readback wrong");
  a_mst_readback: assert property (
    s_mst_wr_rd |=> (reg_rdata & 32'h77777777)
    == ($past(reg_wdata, 2) & 32'h77777777)) else $error("master pri wrong");
  a_done_lowered: assert property (
    reg_rd && reg_addr == l2_arb_pkg::ARB_STATUS_OFS && slave_dma_port_done
    |=> reg_rdata[20:18] == 3'h7) else $error("finished port not at seven");
endmodule // l2_bandwidth_arbiter_chk

// ---- tb/l2_bandwidth_arbiter_tb_top.sv ----
// Bench for arbiter and requester end joined by their link.
// Assumes a 20 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ns
module l2_bandwidth_arbiter_tb_top;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
  logic        clk = 0, rst_n = 0, slave_dma_port_done_in = 0, sw_wr = 0, sw_rd = 0;
  logic        core_req_in = 0, internal_dma_req_in = 0, slave_dma_port_req_in = 0;
  logic [3:0]  slave_dma_port_mid_in = 4'h0;
  logic [24:0] sw_addr = 25'h0;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, r, r2;
  logic [2:0]  gnt_out, slave_dma_port_eff_pri;
  logic        cfg_illegal, core_favoured, ill;
  int          fails = 0, comparisons = 0, cyc = 0, seed = 32'h37599daf;
  int          cpri, ipri, lim, effs, gp, mpri[16], cnt[3];
  bit   [2:0]  pend, msk, gu, st;
  l2_arb_if lnk ();
  l2_bandwidth_arbiter i_l2_bandwidth_arbiter (.clk(clk), .rst_n(rst_n),
    .bus(lnk), .slave_dma_port_eff_pri(slave_dma_port_eff_pri), .core_favoured(core_favoured));
  l2_requester_end i_l2_requester_end (.clk(clk), .rst_n(rst_n), .bus(lnk),
    .core_req_in(core_req_in), .internal_dma_req_in(internal_dma_req_in),
    .slave_dma_port_req_in(slave_dma_port_req_in), .slave_dma_port_done_in(slave_dma_port_done_in),
    .slave_dma_port_mid_in(slave_dma_port_mid_in), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .gnt_out(gnt_out),
    .cfg_illegal(cfg_illegal));
  l2_bandwidth_arbiter_chk i_l2_bandwidth_arbiter_chk (.clk(clk),
    .rst_n(rst_n), .core_req(lnk.core_req), .internal_dma_req(lnk.internal_dma_req),
    .slave_dma_port_req(lnk.slave_dma_port_req), .slave_dma_port_done(lnk.slave_dma_port_done),
    .slave_dma_port_mid(lnk.slave_dma_port_mid), .core_gnt(lnk.core_gnt),
    .internal_dma_gnt(lnk.internal_dma_gnt), .slave_dma_port_gnt(lnk.slave_dma_port_gnt),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata));
  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
  task stop_test;
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Register port cycles, entered just after a rising edge
  task wr(input logic [24:0] a, input logic [31:0] d);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk) sw_wr <= 1'b0;
  endtask
  task rd(input logic [24:0] a, input logic [31:0] e, input logic [31:0] m);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk) sw_rd <= 1'b0;
    @(negedge clk) `CHK(sw_rdata & m, e & m)
    @(posedge clk);
  endtask
  // Model: expected grant and comb outputs in each settled cycle
  always @(negedge clk) if (rst_n) begin
    effs = slave_dma_port_done_in ? 7 : mpri[slave_dma_port_mid_in];
    for (int i = 0; i < 3; i++) st[i] = i > 0 && pend[i] && lim != 0
      && cnt[i] >= lim;
    if (st != 0) msk = st;
    else if (pend[0]) msk = 3'h1;
    else if (pend[2:1] == 2'h3) msk = ipri < effs ? 3'h2 : effs < ipri ? 3'h4
      : 3'h6;
    else msk = pend;
    if ($onehot0(msk)) `CHK(gnt_out, msk)
    else `CHK($onehot(gnt_out) && (gnt_out & ~msk) == 0, 1'b1)
    ill = cpri == 0 || cpri == 7 || ipri >= cpri || mpri[slave_dma_port_mid_in] >= cpri;
    `CHK(cfg_illegal, ill)
    `CHK(slave_dma_port_eff_pri, 3'(effs))
    `CHK(core_favoured, msk == 3'h1 && (pend[1] && ipri <= cpri
      || pend[2] && effs <= cpri))
  end
  // Model: pending, counters and registers; ties follow the granted side
  always @(posedge clk) begin
    if (!rst_n) begin
      pend = 0; msk = 0; cnt = '{0, 0, 0}; cpri = 1; lim = 16; ipri = 2;
      foreach (mpri[i]) mpri[i] = 2;
    end else begin
      gu = $onehot0(msk) ? msk : gnt_out & msk;
      gp = gu[0] ? cpri : gu[1] ? ipri : gu[2] ? effs : 8;
      for (int i = 1; i < 3; i++)
        if (!pend[i] || gu[i]) cnt[i] = 0;
        else if (gp < (i == 1 ? ipri : effs) && cnt[i] < 63) cnt[i]++;
      pend = ~gu & (pend | {slave_dma_port_req_in, internal_dma_req_in, core_req_in});
      if (sw_wr && sw_addr == l2_arb_pkg::CORE_ARB_CTRL_OFS) begin
        cpri = sw_wdata[2:0];
        lim = sw_wdata[21:16];
      end
      if (sw_wr && sw_addr == l2_arb_pkg::INTERNAL_DMA_CH1_COUNT_OFS)
        ipri = sw_wdata[31:29];
      if (sw_wr && sw_addr[24:4] == l2_arb_pkg::MASTER_PRIORITY_0_OFS[24:4]
        || sw_wr && sw_addr == l2_arb_pkg::MASTER_PRIORITY_1_OFS)
        for (int k = 0; k < 8; k++) mpri[k + (sw_addr[6] ? 8 : 0)] =
          sw_wdata[4*k +: 3];
    end
  end
  // Reset values, then random configurations under random traffic
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(l2_arb_pkg::CORE_ARB_CTRL_OFS, 32'h00100001, '1);
    rd(l2_arb_pkg::INTERNAL_DMA_CH1_COUNT_OFS, 32'h40000000, 32'he0000000);
    rd(l2_arb_pkg::MASTER_PRIORITY_1_OFS, 32'h22222222, 32'h77777777);
    rd(25'h0, 32'h0, '1);
    for (int k = 0; k < 24; k++) begin
      core_req_in <= 1'b0;
      internal_dma_req_in <= 1'b0;
      slave_dma_port_req_in <= 1'b0;
      r = $random(seed);
      r2 = $random(seed);
      wr(l2_arb_pkg::CORE_ARB_CTRL_OFS, {13'h0, r[5:3], 13'h0, r[2:0]});
      rd(l2_arb_pkg::CORE_ARB_CTRL_OFS, {13'h0, r[5:3], 13'h0, r[2:0]}, '1);
      wr(l2_arb_pkg::INTERNAL_DMA_CH1_COUNT_OFS, {r[8:6], 29'h0});
      @(posedge clk);
      wr(l2_arb_pkg::MASTER_PRIORITY_0_OFS, r2);
      rd(l2_arb_pkg::MASTER_PRIORITY_0_OFS, r2, 32'h77777777);
      wr(l2_arb_pkg::MASTER_PRIORITY_1_OFS, ~r2);
      slave_dma_port_done_in <= r[9];
      slave_dma_port_mid_in <= r[13:10];
      repeat (2) @(posedge clk);
      rd(l2_arb_pkg::ARB_STATUS_OFS, {11'h0, 3'(effs), 18'h0}, 32'h1c0000);
      repeat (120) begin
        r = $random(seed);
        core_req_in <= r[0] | r[1] | k[0];
        internal_dma_req_in <= r[2];
        slave_dma_port_req_in <= r[3];
        @(posedge clk);
      end
    end
    stop_test;
  end
endmodule // l2_bandwidth_arbiter_tb_top
